//--- src/dtc_timer.v
// Purpose: common control of a two channel 16-bit timer with APB access
// Assumes: pin inputs synchronous to pclk; one clock domain
// Notes:   pins are indexed ch*4 + reg (reg a=0, b=1, c=2, d=3)
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_timer #(
  parameter CW = 16
) (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  // channel pins
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out_q,
  output reg  [7:0]  pin_oe_q
);

  // control registers
  reg [7:0]    run_q;
  reg [7:0]    mode_q;
  reg [7:0]    pwm_q;
  reg [7:0]    setup_q;
  reg [1:0]    clren_q;
  reg [7:0]    capsel_q;
  reg [2:0]    div_q;
  reg [7:0]    prev_q;
  reg          psync_q;
  reg [CW-1:0] cnt_q [0:1];
  reg [CW-1:0] gr_q  [0:7];

  // bus phases: answer on the second access cycle
  // acc marks the first access cycle; ready pulses one cycle after it
  // wr_en fires on the edge where the master samples ready high
  wire acc    = psel & penable & ~pready_q;
  wire wr_en  = psel & penable & pready_q & pwrite;
  wire gr_hit = (paddr[7:5] == `DTC_GR_PAGE) & (paddr[1:0] == 2'b00);

  wire       sync_on = mode_q[`DTC_SYNC_BIT];
  wire [1:0] cmb     = setup_q[`DTC_CMB_MSB:`DTC_CMB_LSB];
  wire [2:0] clk0    = setup_q[`DTC_CLK0_LSB+2:`DTC_CLK0_LSB];
  wire [2:0] clk1    = setup_q[`DTC_CLK1_LSB+2:`DTC_CLK1_LSB];

  // pin edges; capture only where the pin is set as input
  wire [7:0] edge_in = pin_in & ~prev_q;
  wire [7:0] cap_ev  = edge_in & capsel_q;

  // count tick from prescaler or external pin a0
  // one free-running prescaler feeds both channels, so a clock change
  // in mid-count may shorten the first divided period
  function tick_of;
    input [2:0] sel;
    input [2:0] div;
    input       ext;
    begin
      case (sel)
        `DTC_CLK_DIV1: tick_of = 1'b1;
        `DTC_CLK_DIV2: tick_of = div[0];
        `DTC_CLK_DIV4: tick_of = &div[1:0];
        `DTC_CLK_DIV8: tick_of = &div;
        `DTC_CLK_EXT:  tick_of = ext;
        default:       tick_of = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] tick;
  assign tick[0] = tick_of(clk0, div_q, edge_in[0]);
  assign tick[1] = tick_of(clk1, div_q, edge_in[0]);

  // run gating of both channels
  wire [1:0] run = run_q[1:0];

  // compare events per general register
  // a register set for capture gives no compare event
  // combined modes compare every pin against counter 0
  wire [7:0] cmp_ev;
  wire [7:0] lvl;
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_cmp
      assign cmp_ev[k] = run[k/4] & tick[k/4] & ~capsel_q[k]
                         & (cnt_q[k/4] == gr_q[k]);
      assign lvl[k]    = (cnt_q[(cmb != 2'b00) ? 0 : k/4] < gr_q[k]);
    end
  endgenerate

  // clear on a-register event, shared when synchronised
  // only the a-register event clears; the other registers never do
  wire [1:0] clr_own;
  assign clr_own[0] = clren_q[0] & run[0] & (cmp_ev[0] | cap_ev[0]);
  assign clr_own[1] = clren_q[1] & run[1] & (cmp_ev[4] | cap_ev[4]);
  wire [1:0] clr;
  assign clr[0] = clr_own[0] | (sync_on & clr_own[1]);
  assign clr[1] = clr_own[1] | (sync_on & clr_own[0]);

  // preset writes, mirrored to both counters when synchronised
  // a preset needs no run bit, so halted counters can be loaded
  wire [1:0] wcnt;
  assign wcnt[0] = wr_en & (paddr == `DTC_CNT0_OFS);
  assign wcnt[1] = wr_en & (paddr == `DTC_CNT1_OFS);
  wire [1:0] preset;
  assign preset[0] = wcnt[0] | (sync_on & wcnt[1]);
  assign preset[1] = wcnt[1] | (sync_on & wcnt[0]);

  // read mux and address decode
  // unmapped or unaligned places answer with an error and read zero
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (gr_hit) begin
      rd_d[CW-1:0] = gr_q[paddr[4:2]];
    end else begin
      case (paddr)
        `DTC_RUN_OFS:    rd_d[7:0] = run_q;
        `DTC_MODE_OFS:   rd_d[7:0] = mode_q;
        `DTC_PWM_OFS:    rd_d[7:0] = pwm_q;
        `DTC_SETUP_OFS:  rd_d[7:0] = setup_q;
        `DTC_CNT0_OFS:   rd_d[CW-1:0] = cnt_q[0];
        `DTC_CNT1_OFS:   rd_d[CW-1:0] = cnt_q[1];
        `DTC_CLREN_OFS:  rd_d[1:0] = clren_q;
        `DTC_CAPSEL_OFS: rd_d[7:0] = capsel_q;
        default:         err_d = 1'b1;
      endcase
    end
  end

  // apb answer: ready, data and error from flops
  // read data is latched once and held until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & err_d;
      if (acc & ~pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  // control registers; fixed bits forced so writes cannot move them
  // setup, clear-enable and capture-select have no reserved bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q    <= `DTC_RUN_FIXED;
      mode_q   <= `DTC_MODE_FIXED;
      pwm_q    <= `DTC_PWM_FIXED;
      setup_q  <= 8'h00;
      clren_q  <= 2'b00;
      capsel_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        `DTC_RUN_OFS:
          run_q <= (pwdata[7:0] & `DTC_RUN_WMASK) | `DTC_RUN_FIXED;
        `DTC_MODE_OFS:
          mode_q <= (pwdata[7:0] & `DTC_MODE_WMASK) | `DTC_MODE_FIXED;
        `DTC_PWM_OFS:
          pwm_q <= (pwdata[7:0] & `DTC_PWM_WMASK) | `DTC_PWM_FIXED;
        `DTC_SETUP_OFS:  setup_q  <= pwdata[7:0];
        `DTC_CLREN_OFS:  clren_q  <= pwdata[1:0];
        `DTC_CAPSEL_OFS: capsel_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // prescaler and pin history; prescaler is shared, so ticks align
  // pin history starts low like the idle pins, so reset gives no false edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 3'h0;
      prev_q <= 8'h00;
    end else begin
      div_q  <= div_q + 3'h1;
      prev_q <= pin_in;
    end
  end

  // counters: preset beats clear beats count
  // a clear wins over the count on one edge, so a period is match plus one
  integer c;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q[0] <= {CW{1'b0}};
      cnt_q[1] <= {CW{1'b0}};
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        if (preset[c]) begin
          cnt_q[c] <= pwdata[CW-1:0];
        end else if (clr[c]) begin
          cnt_q[c] <= {CW{1'b0}};
        end else if (run[c] & tick[c]) begin
          cnt_q[c] <= cnt_q[c] + {{(CW-1){1'b0}}, 1'b1};
        end
        // halted: only a preset or a shared clear is taken, otherwise the count is held
      end
    end
  end

  // general registers with buffer pairing; software write wins
  // capture and compare of one register never coincide: capsel splits them
  // a software write on the same edge overrides any hardware update
  integer g;
  integer ch;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (g = 0; g < 8; g = g + 1) begin
        gr_q[g] <= {CW{1'b1}};
      end
    end else begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        // c buffers a
        if (mode_q[`DTC_CBUF_BIT + 2*ch]) begin
          if (cap_ev[4*ch]) begin
            gr_q[4*ch]   <= cnt_q[ch];
            gr_q[4*ch+2] <= gr_q[4*ch];
          end else if (cmp_ev[4*ch]) begin
            gr_q[4*ch]   <= gr_q[4*ch+2];
          end
        end else begin
          if (cap_ev[4*ch]) begin
            gr_q[4*ch] <= cnt_q[ch];
          end
          if (cap_ev[4*ch+2]) begin
            gr_q[4*ch+2] <= cnt_q[ch];
          end
        end
        // d buffers b
        if (mode_q[`DTC_DBUF_BIT + 2*ch]) begin
          if (cap_ev[4*ch+1]) begin
            gr_q[4*ch+1] <= cnt_q[ch];
            gr_q[4*ch+3] <= gr_q[4*ch+1];
          end else if (cmp_ev[4*ch+1]) begin
            gr_q[4*ch+1] <= gr_q[4*ch+3];
          end
        end else begin
          if (cap_ev[4*ch+1]) begin
            gr_q[4*ch+1] <= cnt_q[ch];
          end
          if (cap_ev[4*ch+3]) begin
            gr_q[4*ch+3] <= cnt_q[ch];
          end
        end
      end
      if (wr_en & gr_hit) begin
        gr_q[paddr[4:2]] <= pwdata[CW-1:0];
      end
    end
  end

  // pwm sync level toggles at each channel 0 period end
  // it moves only on a clear, so it stays put while both counters are halted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psync_q <= 1'b0;
    end else if (clr[0]) begin
      psync_q <= ~psync_q;
    end
  end

  // pin function select; combined mode has priority over pin bits
  // pin a0 never carries pwm; pin a1 only in the combined modes
  // compare outputs toggle on a match and otherwise keep their level
  reg [7:0] out_d;
  reg [7:0] oe_d;
  integer p;
  always @* begin
    out_d = pin_out_q;
    oe_d  = 8'h00;
    for (p = 0; p < 8; p = p + 1) begin
      if (p == 0 && clk0 == `DTC_CLK_EXT) begin
        oe_d[p] = 1'b0;
      end else if (cmb != 2'b00 && p != 0) begin
        oe_d[p] = 1'b1;
        if (p == 2) begin
          out_d[p] = psync_q;
        end else if (p >= 4 && cmb[1]) begin
          out_d[p] = ~lvl[p];
        end else begin
          out_d[p] = lvl[p];
        end
      end else if (p != 0 && p != 4 && pwm_q[p-1]) begin
        oe_d[p]  = 1'b1;
        out_d[p] = lvl[p];
      end else if (capsel_q[p]) begin
        oe_d[p] = 1'b0;
      end else begin
        oe_d[p] = 1'b1;
        if (cmp_ev[p]) begin
          out_d[p] = ~pin_out_q[p];
        end
      end
    end
  end

  // registered pin drive
  // one cycle of delay is traded for outputs free of decode glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 8'h00;
      pin_oe_q  <= 8'h00;
    end else begin
      pin_out_q <= out_d;
      pin_oe_q  <= oe_d;
    end
  end

endmodule

//--- src/dtc_map.vh
// Purpose: register map and constants of the dual channel timer control
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   reserved bits are folded into the reset and fixed masks
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// register byte offsets
`define DTC_RUN_OFS    8'h00
`define DTC_MODE_OFS   8'h04
`define DTC_PWM_OFS    8'h08
`define DTC_SETUP_OFS  8'h0C
`define DTC_CNT0_OFS   8'h10
`define DTC_CNT1_OFS   8'h14
`define DTC_CLREN_OFS  8'h18
`define DTC_CAPSEL_OFS 8'h1C
`define DTC_GR_PAGE    3'h1

// writable bits and bits fixed at one
`define DTC_RUN_WMASK  8'h03
`define DTC_RUN_FIXED  8'hFC
`define DTC_MODE_WMASK 8'hF1
`define DTC_MODE_FIXED 8'h0E
`define DTC_PWM_WMASK  8'h77
`define DTC_PWM_FIXED  8'h88

// field positions
`define DTC_SYNC_BIT   0
`define DTC_CBUF_BIT   4
`define DTC_DBUF_BIT   5
`define DTC_CMB_LSB    0
`define DTC_CMB_MSB    1
`define DTC_CLK0_LSB   2
`define DTC_CLK1_LSB   5

// count clock selections
`define DTC_CLK_DIV1   3'h0
`define DTC_CLK_DIV2   3'h1
`define DTC_CLK_DIV4   3'h2
`define DTC_CLK_DIV8   3'h3
`define DTC_CLK_EXT    3'h4

`endif

//--- testbench/dtc_chk.sv
// Purpose: apb timing and reserved bit checks for dtc_timer
// Assumes: one clock, async reset active low
// Notes:   bound to the top ports only
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_chk (
  // clock, reset, apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_q,
  input wire        pready_q,
  input wire        pslverr_q,
  // pins
  input wire [7:0]  pin_in,
  input wire [7:0]  pin_out_q,
  input wire [7:0]  pin_oe_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a finished read; the master still holds its address here
  wire rd = pready_q && !pwrite;
  a_rdy_pulse: assert property (pready_q |=> !pready_q) else $error("ready held");
  a_rdy_cause: assert property (pready_q |-> psel && penable && $past(penable))
    else $error("ready unasked");
  a_rdy_time: assert property (psel && !penable |-> ##2 pready_q) else $error("ready late");
  a_err_rdy: assert property (pslverr_q |-> pready_q) else $error("error alone");
  a_unmapped_err: assert property (pready_q && paddr >= 8'h40 |-> pslverr_q)
    else $error("no error");
  a_run_fixed: assert property (rd && paddr == `DTC_RUN_OFS |->
    prdata_q[31:2] == 30'h0000_003F) else $error("run reserved");
  a_mode_fixed: assert property (rd && paddr == `DTC_MODE_OFS |-> prdata_q[3:1] == 3'h7)
    else $error("mode reserved");
  a_pwm_fixed: assert property (rd && paddr == `DTC_PWM_OFS |-> prdata_q[7] && prdata_q[3])
    else $error("pwm reserved");
  c_cnt_rd: cover property (rd && paddr == `DTC_CNT0_OFS);
  c_err: cover property (pslverr_q);
  c_cap: cover property (!pin_oe_q[0] && $rose(pin_in[0]));
  c_sync_pin: cover property (pin_oe_q[2] && $rose(pin_out_q[2]));
endmodule
bind dtc_timer dtc_chk dtc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata_q, .pready_q, .pslverr_q, .pin_in, .pin_out_q, .pin_oe_q);

//--- testbench/dtc_pins.sv
// Purpose: external signal sources on the eight timer pins
// Assumes: requests from the bench last one cycle
// Notes:   sources idle low; the design wins where it drives
`timescale 1ns/1ps
module dtc_pins (
  // clock, reset, requests and design side
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] req,
  input  wire [7:0] pin_out_q,
  input  wire [7:0] pin_oe_q,
  output wire [7:0] pin_in
);
  reg [7:0] drv_q;
  // one-cycle pulse so each request gives exactly one rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) drv_q <= 8'h00;
    else drv_q <= req;
  end
  // wire level from the design's enable; the bench drives the rest
  assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & drv_q);
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench of dtc_timer
// Assumes: apb master with bounded waits
// Notes:   counters stay halted while pins are judged, except pin c0 in the clear test
`timescale 1ns/1ps
`include "dtc_map.vh"
module testbench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg  [7:0]  paddr = 8'h00, req = 8'h00;
  reg  [31:0] pwdata = 32'h0000_0000, rv, h, g;
  wire [31:0] prdata_q;
  wire        pready_q, pslverr_q;
  wire [7:0]  pin_in, pin_out_q, pin_oe_q;
  integer     errors = 0, samples_checked = 0, i, k, n;
  always #12.5 pclk = ~pclk;
  dtc_timer dtc_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .pin_in, .pin_out_q, .pin_oe_q);
  dtc_pins dtc_pins_inst (.pclk, .presetn, .req, .pin_out_q, .pin_oe_q, .pin_in);
  task close_out;
    begin
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] gv, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (gv !== e) begin
        errors = errors + 1;
        $display("ERROR %0t got %h exp %h", $time, gv, e);
      end
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do @(posedge pclk); while (pready_q !== 1'b1 && ++n < 20);
      if (n >= 20) begin
        errors = errors + 1;
        close_out;
      end else begin
        rv = prdata_q;
        er = pslverr_q;
        {psel, penable} <= 2'b00;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      apb(a, 0, 0);
      chk(rv, e);
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge pclk);
  endtask
  // reset values, writes to reserved bits, unmapped place
  task t_regs;
    begin
      rd(`DTC_RUN_OFS, 32'h0000_00FC);
      wr(`DTC_MODE_OFS, 32'h0000_0000);
      rd(`DTC_MODE_OFS, 32'h0000_000E);
      wr(`DTC_PWM_OFS, 32'h0000_0077);
      rd(`DTC_PWM_OFS, 32'h0000_00FF);
      wr(`DTC_PWM_OFS, 32'h0000_0000);
      rd(`DTC_PWM_OFS, 32'h0000_0088);
      rd(8'h40, 32'h0000_0000);
      chk(er, 1);
      $display("done regs");
    end
  endtask
  // start, halt, resume; channel 1 on the divide-by-8 clock
  task t_run;
    begin
      wr(`DTC_SETUP_OFS, 32'h0000_0060);
      wr(`DTC_RUN_OFS, 32'h0000_0003);
      tick(60);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      apb(`DTC_CNT0_OFS, 0, 0);
      h = rv;
      apb(`DTC_CNT1_OFS, 0, 0);
      g = rv;
      chk(g >= h / 8 && g <= h / 8 + 1 && h > 40, 1);
      wr(`DTC_RUN_OFS, 32'h0000_0001);
      tick(20);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      rd(`DTC_CNT1_OFS, g);
      apb(`DTC_CNT0_OFS, 0, 0);
      chk(rv > h, 1);
      h = rv;
      wr(`DTC_RUN_OFS, 32'h0000_0002);
      tick(20);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      rd(`DTC_CNT0_OFS, h);
      apb(`DTC_CNT1_OFS, 0, 0);
      chk(rv > g, 1);
      wr(`DTC_CNT0_OFS, 32'h0000_0000);
      wr(`DTC_CNT1_OFS, 32'h0000_0000);
      wr(`DTC_SETUP_OFS, 32'h0000_0044);
      wr(`DTC_RUN_OFS, 32'h0000_0003);
      tick(60);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      apb(`DTC_CNT0_OFS, 0, 0);
      h = rv;
      apb(`DTC_CNT1_OFS, 0, 0);
      chk(rv >= h / 2 - 1 && rv <= h / 2 + 1 && h > 20, 1);
      wr(`DTC_SETUP_OFS, 32'h0000_0000);
      $display("done run");
    end
  endtask
  // counter writes shared only with sync set
  task t_sync;
    begin
      wr(`DTC_CNT1_OFS, 32'h0000_0000);
      wr(`DTC_CNT0_OFS, 32'h0000_1234);
      rd(`DTC_CNT1_OFS, 32'h0000_0000);
      wr(`DTC_MODE_OFS, 32'h0000_0001);
      wr(`DTC_CNT0_OFS, 32'h0000_0055);
      rd(`DTC_CNT1_OFS, 32'h0000_0055);
      wr(`DTC_CNT1_OFS, 32'h0000_0066);
      rd(`DTC_CNT0_OFS, 32'h0000_0066);
      $display("done sync");
    end
  endtask
  // capture into a or b with each buffer bit; old value must move on
  task t_buf;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        k = (i % 2) + 4 * ((i / 2) % 2);
        wr(8'(8'h10 + 4 * ((i / 2) % 2)), 32'h0100 + i);
        wr(8'(8'h20 + 4 * k), 32'h0200 + i);
        wr(`DTC_MODE_OFS, i < 4 ? 32'h10 << i : 32'h0);
        wr(`DTC_CAPSEL_OFS, 32'h1 << k);
        @(posedge pclk) req <= 8'(1 << k);
        @(posedge pclk) req <= 8'h00;
        tick(3);
        rd(8'(8'h20 + 4 * k), 32'h0100 + i);
        rd(8'(8'h28 + 4 * k), i < 4 ? 32'h0200 + i : 32'h0000_0200);
      end
      $display("done buffer");
    end
  endtask
  // each pwm bit turns its pin into counter < register
  task t_pwm;
    begin
      wr(`DTC_CAPSEL_OFS, 32'h0000_0000);
      for (k = 1; k < 8; k = k + 1) if (k != 4) begin
        wr(`DTC_PWM_OFS, 32'h1 << (k - 1));
        wr(8'(8'h20 + 4 * k), 32'h0000_8000);
        wr(8'(8'h10 + 4 * (k / 4)), 32'h0000_0010);
        tick(2);
        chk({pin_oe_q[k], pin_out_q[k]}, 3);
        wr(8'(8'h10 + 4 * (k / 4)), 32'h0000_9000);
        tick(2);
        chk({pin_oe_q[k], pin_out_q[k]}, 2);
      end
      $display("done pwm");
    end
  endtask
  // combined mode: pin a1 follows counter 0 against register a1
  task t_cmb;
    begin
      wr(`DTC_PWM_OFS, 32'h0000_0000);
      wr(`DTC_SETUP_OFS, 32'h0000_0001);
      wr(8'h30, 32'h0000_8000);
      wr(`DTC_CNT0_OFS, 32'h0000_0010);
      tick(2);
      chk({pin_oe_q[4], pin_out_q[4]}, 3);
      wr(`DTC_CNT0_OFS, 32'h0000_9000);
      tick(2);
      chk({pin_oe_q[4], pin_out_q[4]}, 2);
      wr(`DTC_SETUP_OFS, 32'h0000_0002);
      tick(2);
      chk({pin_oe_q[4], pin_out_q[4]}, 3);
      $display("done combined");
    end
  endtask
  // a-register match clears counter 0, both only with sync; pin c0 toggles
  task t_clr;
    begin
      wr(`DTC_SETUP_OFS, 32'h0000_0001);
      wr(`DTC_PWM_OFS, 32'h0000_0002);
      wr(`DTC_CNT0_OFS, 32'h0000_0000);
      wr(`DTC_CNT1_OFS, 32'h0000_0000);
      wr(8'h20, 32'h0000_0010);
      wr(`DTC_CLREN_OFS, 32'h0000_0001);
      chk({pin_oe_q[2], pin_out_q[2]}, 2);
      wr(`DTC_RUN_OFS, 32'h0000_0003);
      n = 0;
      while (pin_out_q[2] !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n = n + 1;
      end
      chk(n < 40, 1);
      if (n >= 40) close_out;
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      apb(`DTC_CNT0_OFS, 0, 0);
      chk(rv < 16, 1);
      apb(`DTC_CNT1_OFS, 0, 0);
      chk(rv > 16, 1);
      wr(`DTC_MODE_OFS, 32'h0000_0001);
      wr(`DTC_CNT0_OFS, 32'h0000_0000);
      wr(`DTC_RUN_OFS, 32'h0000_0003);
      tick(20);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      apb(`DTC_CNT0_OFS, 0, 0);
      h = rv;
      chk(h < 16, 1);
      rd(`DTC_CNT1_OFS, h);
      wr(`DTC_MODE_OFS, 32'h0000_0000);
      wr(`DTC_CLREN_OFS, 32'h0000_0000);
      $display("done clear");
    end
  endtask
  // rising edges on pin a0 clock both counters
  task t_ext;
    begin
      wr(`DTC_SETUP_OFS, 32'h0000_0090);
      wr(`DTC_CNT0_OFS, 32'h0000_0000);
      wr(`DTC_CNT1_OFS, 32'h0000_0000);
      chk(pin_oe_q[0], 0);
      wr(`DTC_RUN_OFS, 32'h0000_0003);
      repeat (3) begin
        @(posedge pclk) req <= 8'h01;
        @(posedge pclk) req <= 8'h00;
      end
      tick(3);
      wr(`DTC_RUN_OFS, 32'h0000_0000);
      rd(`DTC_CNT0_OFS, 32'h0000_0003);
      rd(`DTC_CNT1_OFS, 32'h0000_0003);
      wr(`DTC_SETUP_OFS, 32'h0000_0000);
      $display("done external");
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_run;
    t_sync;
    t_buf;
    t_pwm;
    t_cmb;
    t_clr;
    t_ext;
    close_out;
  end
endmodule
